//--- inc/angle_pll_cfg.svh
// Register map, field layout and timing constants of the angle PLL lock and sync block
`ifndef ANGLE_PLL_CFG_SVH
`define ANGLE_PLL_CFG_SVH
`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004
`define OFF_TRIG_SYNC   12'h008
`define OFF_STATE_SYNC  12'h00c
`define OFF_CORR        12'h010
`define OFF_PULSE       12'h014
`define OFF_IRQ_STAT    12'h018
`define OFF_IRQ_MASK    12'h01c
`define BIT_EMERG       0
`define BIT_WRITE_SYNC_ENABLE        1
`define BIT_REQ         0
`define BIT_FLAG        1
`define BIT_INCOPT      2
`define SYN_LSB         0
`define SYN_MSB         5
`define OLD_LSB         8
`define OLD_MSB         13
`define AMT_LSB         16
`define AMT_MSB         31
`define PUL_T_LSB       0
`define PUL_T_MSB       15
`define PUL_S_LSB       16
`define PUL_S_MSB       31
`define GAP_RELOCK      3'h4
`define CORR_STEP_NS    10
`define CORR_STEP_CYC   ((`CORR_STEP_NS + 9) / 10)
`define IRQ_W           3
`define IRQ_DIR         0
`define IRQ_GAP         1
`define IRQ_DONE        2
`endif

//--- inc/angle_pll_pkg.sv
// Types shared by the angle PLL lock and sync block
`default_nettype none
package angle_pll_pkg;
  typedef enum logic [1:0] {
    CORR_IDLE = 2'b00,
    CORR_RUN  = 2'b01,
    CORR_DONE = 2'b10
  } corr_state_t;
  typedef logic [5:0]  syn_t;
  typedef logic [15:0] cnt_t;
endpackage
`default_nettype wire

//--- core/angle_pll_lock_sync_update.sv
// Lock flag, sync-number registers and fast pulse correction of the angle PLL
// Operation
// - In emergency mode a direction change clears the first lock flag.
// - After such a clear, the lock flag sets again after four missing-state gaps.
// - With write sync enabled, a sync write loads current and old fields from data.
// - Request bit clears when the fast correction completes; software may poll it.
// - With flag set and option clear, add pulse amount to stored pulses and targets.
// - Extra pulses appear on inc_pulse and the increment counter during correction.
//
// The address map and register access over APB were left to the implementer.
`include "angle_pll_cfg.svh"
`default_nettype none
module angle_pll_lock_sync_update (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dir_change,
  input  wire logic        missing_state,
  input  wire logic        input_event,
  output logic             first_lock_flag,
  output logic             inc_pulse,
  output logic [15:0]      inc_count,
  output logic             irq
);
  logic                     emergency_mode_select_q;
  logic                     write_sync_enable_q;
  angle_pll_pkg::syn_t      trig_syn_q, trig_old_q, state_syn_q, state_old_q;
  logic                     fast_correction_request_q;
  logic                     fast_correction_flag_q;
  logic                     increment_count_option_q;
  angle_pll_pkg::cnt_t      additional_pulse_amount_q;
  angle_pll_pkg::cnt_t      stored_trigger_pulses_q, stored_state_pulses_q;
  angle_pll_pkg::cnt_t      target_pulses_q, pending_add_q, remain_q;
  angle_pll_pkg::corr_state_t corr_q;
  logic [2:0]               gap_q;
  logic                     relock_q;
  logic [`IRQ_W-1:0]        irq_stat_q, irq_mask_q, irq_ev;
  logic                     wr, rd, corr_done;

  // Access phase strobes; slave answers with no wait state
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // Control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emergency_mode_select_q   <= 1'b0;
      write_sync_enable_q       <= 1'b0;
      fast_correction_flag_q    <= 1'b0;
      increment_count_option_q  <= 1'b0;
      additional_pulse_amount_q <= '0;
    end else if (wr && hit(paddr, `OFF_CTRL)) begin
      emergency_mode_select_q <= pwdata[`BIT_EMERG];
      write_sync_enable_q     <= pwdata[`BIT_WRITE_SYNC_ENABLE];
    end else if (wr && hit(paddr, `OFF_CORR)) begin
      fast_correction_flag_q    <= pwdata[`BIT_FLAG];
      increment_count_option_q  <= pwdata[`BIT_INCOPT];
      additional_pulse_amount_q <= pwdata[`AMT_MSB:`AMT_LSB];
    end
  end

  // Sync numbers: old field takes written bits, not the previous current value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_syn_q  <= '0;
      trig_old_q  <= '0;
      state_syn_q <= '0;
      state_old_q <= '0;
    end else if (wr && write_sync_enable_q) begin
      if (hit(paddr, `OFF_TRIG_SYNC)) begin
        trig_syn_q <= pwdata[`SYN_MSB:`SYN_LSB];
        trig_old_q <= pwdata[`OLD_MSB:`OLD_LSB];
      end
      if (hit(paddr, `OFF_STATE_SYNC)) begin
        state_syn_q <= pwdata[`SYN_MSB:`SYN_LSB];
        state_old_q <= pwdata[`OLD_MSB:`OLD_LSB];
      end
    end
  end

  // Lock flag: relock needs four gaps, two more than ideal; kept as built
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_lock_flag <= 1'b0;
      gap_q           <= '0;
      relock_q        <= 1'b0;
    end else if (emergency_mode_select_q && dir_change) begin
      first_lock_flag <= 1'b0;
      gap_q           <= '0;
      relock_q        <= 1'b1;
    end else if (relock_q && missing_state) begin
      if (gap_q + 3'h1 == `GAP_RELOCK) begin
        first_lock_flag <= 1'b1;
        relock_q        <= 1'b0;
        gap_q           <= '0;
      end else begin
        gap_q <= gap_q + 3'h1;
      end
    end else if (!relock_q && !emergency_mode_select_q) begin
      first_lock_flag <= 1'b1;
    end
  end

  // Fast correction: emits one extra pulse per cycle, then drops the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_q                    <= angle_pll_pkg::CORR_IDLE;
      fast_correction_request_q <= 1'b0;
      remain_q                  <= '0;
      inc_pulse                 <= 1'b0;
      inc_count                 <= '0;
    end else begin
      inc_pulse <= 1'b0;
      unique case (corr_q)
        angle_pll_pkg::CORR_IDLE: begin
          if (wr && hit(paddr, `OFF_CORR) && pwdata[`BIT_REQ]) begin
            fast_correction_request_q <= 1'b1;
            remain_q <= pwdata[`AMT_MSB:`AMT_LSB];
            corr_q   <= angle_pll_pkg::CORR_RUN;
          end
        end
        angle_pll_pkg::CORR_RUN: begin
          if (remain_q == '0) begin
            corr_q <= angle_pll_pkg::CORR_DONE;
          end else begin
            inc_pulse <= 1'b1;
            inc_count <= inc_count + 16'h0001;
            remain_q  <= remain_q - 16'h0001;
          end
        end
        angle_pll_pkg::CORR_DONE: begin
          fast_correction_request_q <= 1'b0;
          corr_q <= angle_pll_pkg::CORR_IDLE;
        end
        default: corr_q <= angle_pll_pkg::CORR_IDLE;
      endcase
    end
  end

  assign corr_done = (corr_q == angle_pll_pkg::CORR_DONE);

  // Pulse bookkeeping: amount is held until the next input event, which applies it unless a pulse write lands in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_add_q           <= '0;
      stored_trigger_pulses_q <= '0;
      stored_state_pulses_q   <= '0;
      target_pulses_q         <= '0;
    end else begin
      if (wr && hit(paddr, `OFF_PULSE)) begin
        stored_trigger_pulses_q <= pwdata[`PUL_T_MSB:`PUL_T_LSB];
        stored_state_pulses_q   <= pwdata[`PUL_S_MSB:`PUL_S_LSB];
      end else if (input_event) begin
        stored_trigger_pulses_q <= stored_trigger_pulses_q + pending_add_q;
        stored_state_pulses_q   <= stored_state_pulses_q + pending_add_q;
        target_pulses_q         <= target_pulses_q + pending_add_q;
      end
      if (corr_done && fast_correction_flag_q && !increment_count_option_q) begin
        pending_add_q <= remain_q + additional_pulse_amount_q;
      end else if (input_event) begin
        pending_add_q <= '0;
      end
    end
  end

  // Interrupt status: event set beats the read clear
  assign irq_ev = {corr_done, missing_state, emergency_mode_select_q && dir_change};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq        <= 1'b0;
    end else begin
      if (rd && hit(paddr, `OFF_IRQ_STAT)) begin
        irq_stat_q <= irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      if (wr && hit(paddr, `OFF_IRQ_MASK)) begin
        irq_mask_q <= pwdata[`IRQ_W-1:0];
      end
      irq <= |((irq_stat_q | irq_ev) & irq_mask_q);
    end
  end

  // APB read data and unmapped-address error, registered for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `OFF_IRQ_MASK || paddr[1:0] != 2'b00);
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `OFF_CTRL:       prdata <= {30'h0, write_sync_enable_q, emergency_mode_select_q};
          `OFF_STATUS:     prdata <= {target_pulses_q, 14'h0, relock_q, first_lock_flag};
          `OFF_TRIG_SYNC:  prdata <= {18'h0, trig_old_q, 2'h0, trig_syn_q};
          `OFF_STATE_SYNC: prdata <= {18'h0, state_old_q, 2'h0, state_syn_q};
          `OFF_CORR:       prdata <= {additional_pulse_amount_q, 13'h0,
                                      increment_count_option_q, fast_correction_flag_q,
                                      fast_correction_request_q};
          `OFF_PULSE:      prdata <= {stored_state_pulses_q, stored_trigger_pulses_q};
          // Event of the setup cycle is shown too, else the access-edge clear loses it
          `OFF_IRQ_STAT:   prdata <= {29'h0, irq_stat_q | irq_ev};
          `OFF_IRQ_MASK:   prdata <= {29'h0, irq_mask_q};
          default:         prdata <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/angle_pll_lock_sync_update_checker.sv
// Port-level assertion checker for the angle PLL lock and sync block
`default_nettype none
module angle_pll_lock_sync_update_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dir_change,
  input wire logic        missing_state,
  input wire logic        first_lock_flag,
  input wire logic [15:0] inc_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       emerg_q;
  logic [2:0] gaps_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mirror of the emergency bit, taken only at a completed write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) emerg_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == 12'h000) emerg_q <= pwdata[0];
  end
  // Gaps since the last clear; 7 means no relock is being counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gaps_q <= 3'h7;
    else if (emerg_q && dir_change) gaps_q <= 3'h0;
    else if (missing_state && gaps_q != 3'h7) gaps_q <= gaps_q + 3'h1;
  end
  AST_READY: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  AST_UNMAPPED: assert property (pready && paddr > 12'h01c |-> pslverr)
    else $error("unmapped access not refused");
  AST_UNMAPPED_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_DIR_CLEAR: assert property (emerg_q && dir_change |=> !first_lock_flag)
    else $error("lock flag not cleared");
  AST_RELOCK_COUNT: assert property (emerg_q && $rose(first_lock_flag) |-> gaps_q == 3'h4)
    else $error("relock after wrong gap count");
  AST_LOCK_HOLD: assert property (
    emerg_q && gaps_q < 3'h4 && !missing_state |=> !first_lock_flag)
    else $error("lock flag set early");
  AST_INC_STEP: assert property ($changed(inc_count) |-> inc_count == $past(inc_count) + 16'h1)
    else $error("pulse count jumped");
  // Main scenarios reached
  CV_DIR: cover property (emerg_q && dir_change);
  CV_RELOCK: cover property (emerg_q && $rose(first_lock_flag));
  CV_ERR: cover property (pready && pslverr);
endmodule
bind angle_pll_lock_sync_update angle_pll_lock_sync_update_checker checker_i (.*);
`default_nettype wire

//--- tb/angle_pll_lock_sync_update_tb.sv
// Self-checking bench for the angle PLL lock and sync block
`default_nettype none
module angle_pll_lock_sync_update_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, p0;
  logic        pready, pslverr, er, first_lock_flag, inc_pulse, irq;
  logic        dir_change = 0, missing_state = 0, input_event = 0;
  logic [15:0] inc_count, amt;
  int          error_cnt = 0, check_count = 0, pulses = 0, syn[2];
  always #5 pclk = ~pclk;
  angle_pll_lock_sync_update dut (.*);
  // Extra pulses counted like a flop so the count never races the design
  always @(posedge pclk) pulses += inc_pulse;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    // Answer and read data are taken at the rising edge that sees pready high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask
  // Event pulses: 0 direction change, 1 missing state, 2 input event
  task automatic pulse(input int k);
    @(posedge pclk) {input_event, missing_state, dir_change} <= 3'(1 << k);
    @(posedge pclk) {input_event, missing_state, dir_change} <= 3'b000;
  endtask
  task automatic summarize();
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cuts a hang short, well beyond the under two hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    summarize();
  end
  initial begin
    amt = 16'($urandom(85957));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 2; i++) rdchk(12'h008 + 12'(4 * i), 32'h3f3f, 0, "sync reset");
    rdchk(12'h020, 32'hffffffff, 0, "unmapped data");
    chk("unmapped error", 1, er);
    // Refused while write sync is off, then current and old come from the data
    for (int i = 0; i < 4; i++) begin
      pwdata <= $urandom;
      @(negedge pclk);
      p0 = pwdata;
      if (i == 2) apb(1'b1, 12'h000, 32'h2);
      apb(1'b1, 12'h008 + 12'(4 * (i % 2)), p0);
      if (i > 1) syn[i % 2] = p0 & 32'h3f3f;
      rdchk(12'h008 + 12'(4 * (i % 2)), 32'h3f3f, syn[i % 2], "sync field");
    end
    // Software keeps history by copying the read current field into the old bits
    p0 = $urandom & 32'h3f;
    apb(1'b0, 12'h008, 32'h0);
    apb(1'b1, 12'h008, p0 | ((rd & 32'h3f) << 8));
    rdchk(12'h008, 32'h3f3f, p0 | ((syn[0] & 32'h3f) << 8), "sync history");
    apb(1'b1, 12'h01c, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    apb(1'b1, 12'h000, 32'h3);
    chk("lock before", 1, first_lock_flag);
    pulse(0);
    @(negedge pclk);
    chk("lock cleared", 0, first_lock_flag);
    for (int i = 1; i <= 4; i++) begin
      pulse(1);
      repeat (2) @(negedge pclk);
      chk("relock", i == 4, first_lock_flag);
    end
    // Masked events stay quiet until unmasked; a status read clears them
    chk("irq masked", 0, irq);
    apb(1'b1, 12'h01c, 32'h7);
    repeat (2) @(negedge pclk);
    chk("irq raised", 1, irq);
    rdchk(12'h018, 32'h7, 32'h3, "irq status");
    rdchk(12'h018, 32'h7, 32'h0, "irq cleared");
    chk("irq low", 0, irq);
    // Software spots a gap from its status bit instead of waiting on the flag
    pulse(1);
    rdchk(12'h018, 32'h2, 32'h2, "gap event");
    // Fast correction with a random amount, polled to completion
    apb(1'b0, 12'h014, 32'h0);
    p0 = rd;
    amt = 16'($urandom_range(8, 1));
    apb(1'b1, 12'h010, {amt, 16'h0003});
    rdchk(12'h010, 32'h1, 32'h1, "request busy");
    while (rd[0]) apb(1'b0, 12'h010, 32'h0);
    @(negedge pclk);
    chk("extra pulses", 32'(amt), pulses);
    chk("pulse count", 32'(amt), inc_count);
    rdchk(12'h018, 32'h7, 32'h4, "done event");
    pulse(2);
    rdchk(12'h014, 32'hffffffff, p0 + {amt, amt}, "stored pulses");
    rdchk(12'h004, 32'hffff0000, {amt, 16'h0}, "target pulses");
    summarize();
  end
endmodule
`default_nettype wire
